// >>> testbench/rev_limit_host.sv
/*
  host model that writes and reads the threshold registers.
  assumes the decoded byte port takes a strobe on the rising edge.
*/
`timescale 1ns/10ps
module rev_limit_host (
  // bus side
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // idle bus from time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // callers keep codes inside the usable span per gain
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d; // stale data must not look valid
  endtask
  // read data lands on the taken edge, sampled just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// >>> testbench/reverse_overcurrent_threshold_regs_bench.sv
/*
  self-checking bench for the reverse threshold registers.
  assumes the host model drives the register port.
*/
`timescale 1ns/10ps
module reverse_overcurrent_threshold_regs_bench;
  logic clk = 1'b0, rst_n = 1'b0, rev = 1'b0, wr, rd, alert;
  logic [1:0] gain = 2'b00, unmask = 2'b00, clr = 2'b00, flags;
  logic [7:0] addr, wdata, rdata, d;
  logic signed [26:0] cur = 27'sd0, thr2, thr3;
  int errors = 0, n_compared = 0;
  int st[4] = '{81920, 40960, 27307, 20480};
  int cm[4] = '{6, 12, 18, 24};
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  rev_limit_host host_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  reverse_overcurrent_threshold_regs dut_u (.i_clk(clk), .i_reset_n(rst_n),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_sense_gain_select(gain), .i_reverse_mode(rev),
    .i_reverse_current_ua(cur), .i_alert_unmask(unmask),
    .i_flag_clear(clr), .o_second_threshold_ua(thr2),
    .o_third_threshold_ua(thr3), .o_limit_flags(flags), .o_alert(alert));
  task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [26:0] thr(int c, int s);
    return 27'(c * s - 150000);
  endfunction
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // present trip inputs, then look just after the sampling edge
  task automatic step(input logic r, input int c, input logic [1:0] m);
    @(posedge clk);
    rev <= r;
    cur <= 27'(c);
    unmask <= m;
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    host_u.rd(8'h23, d);
    chk(27'(d), 27'h64);
    host_u.rd(8'h24, d);
    chk(27'(d), 27'hff);
    host_u.rd(8'h25, d);
    chk(27'(d), 27'h0);
    chk(thr2, thr(100, 81920));
  endtask
  // every gain code, highest code on one register and lowest on the other
  task automatic t_gain;
    for (int g = 0; g < 4; g++) begin
      @(posedge clk) gain <= 2'(g);
      host_u.wr(8'h23, 8'hff);
      host_u.wr(8'h24, 8'(cm[g]));
      repeat (2) @(posedge clk);
      #1;
      chk(thr2, thr(255, st[g]));
      chk(thr3, thr(cm[g], st[g]));
      host_u.rd(8'h24, d);
      chk(27'(d), 27'(cm[g]));
    end
  endtask
  // strict compare, direction gate, sticky flag, clear and mask
  task automatic t_trip;
    @(posedge clk) gain <= 2'b00;
    host_u.wr(8'h23, 8'h06);
    repeat (2) @(posedge clk);
    step(1'b0, 341521, 2'b11);
    chk(27'(flags), 27'h0);
    step(1'b1, 341520, 2'b11);
    chk(27'(flags), 27'h0);
    step(1'b1, 341521, 2'b11);
    chk(27'(flags), 27'h1);
    @(posedge clk) rev <= 1'b0;
    #1;
    chk(27'(alert), 27'h1);
    @(posedge clk) clr <= 2'b11;
    @(posedge clk) clr <= 2'b00;
    #1;
    chk(27'(flags), 27'h0);
    step(1'b1, 341521, 2'b00);
    @(posedge clk);
    #1;
    chk(27'(alert), 27'h0);
  endtask
  // third limit trip at 20x, set beats clear, unmask of the third flag
  task automatic t_third;
    @(posedge clk);
    rev <= 1'b0;
    gain <= 2'b01;
    host_u.wr(8'h24, 8'h0c);
    repeat (2) @(posedge clk);
    #1;
    chk(thr3, thr(12, 40960));
    step(1'b1, 341521, 2'b10);
    chk(27'(flags), 27'h3);
    @(posedge clk) clr <= 2'b01;
    @(posedge clk) clr <= 2'b00;
    #1;
    chk(27'(flags), 27'h3);
    chk(27'(alert), 27'h1);
    step(1'b0, 0, 2'b10);
    @(posedge clk) clr <= 2'b11;
    @(posedge clk) clr <= 2'b00;
    #1;
    chk(27'(flags), 27'h0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gain();
    t_trip();
    t_third();
    close_out();
  end
  // watchdog well past the expected run of about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule

// >>> verilog/rev_limit_pkg.sv
/*
  constants for the reverse over-current threshold register pair.
  assumes a decoded byte-wide register port from the serial interface.
*/
// Overview of operation
// - second limit register: 8-bit RW, reset 0x64
// - threshold equals code times step minus 0.15 A
// - gain select bits 00..11 mean 10x..40x
// - third limit register: 8-bit RW, reset 0xFF
// - thresholds act only during reverse power flow
package rev_limit_pkg;
  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_LIMIT_TWO = 8'h23;
  localparam logic [7:0] ADDR_LIMIT_THREE = 8'h24;
  localparam logic [7:0] RESET_LIMIT_TWO = 8'h64;
  localparam logic [7:0] RESET_LIMIT_THREE = 8'hFF;
  // ----------------------------------------------------------
  // threshold arithmetic, currents in microamps
  // ----------------------------------------------------------
  localparam int THR_W = 27;
  localparam logic signed [26:0] OFFSET_UA = 27'sd150000;
  localparam logic [16:0] STEP_GAIN10_UA = 17'd81920;
  localparam logic [16:0] STEP_GAIN20_UA = 17'd40960;
  localparam logic [16:0] STEP_GAIN30_UA = 17'd27307;
  localparam logic [16:0] STEP_GAIN40_UA = 17'd20480;
  localparam logic [1:0] GAIN_SEL_10X = 2'b00;
  localparam logic [1:0] GAIN_SEL_20X = 2'b01;
  localparam logic [1:0] GAIN_SEL_30X = 2'b10;
  localparam logic [1:0] GAIN_SEL_40X = 2'b11;
endpackage

// >>> verilog/reverse_overcurrent_threshold_regs.sv
/*
  reverse over-current threshold registers with their comparators.
  assumes the serial front end gives decoded byte accesses, and that the
  current measurement and direction come from logic on i_clk.
*/
`timescale 1ns/10ps
module reverse_overcurrent_threshold_regs
  import rev_limit_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // analog side
  input wire logic [1:0] i_sense_gain_select,
  input wire logic i_reverse_mode,
  input wire logic signed [26:0] i_reverse_current_ua,
  // status and alert
  input wire logic [1:0] i_alert_unmask,
  input wire logic [1:0] i_flag_clear,
  output logic signed [26:0] o_second_threshold_ua,
  output logic signed [26:0] o_third_threshold_ua,
  output logic [1:0] o_limit_flags,
  output logic o_alert
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // step per code follows the selected sense gain
  function automatic logic [16:0] step_of(input logic [1:0] gain);
    logic [16:0] s;
    s = STEP_GAIN10_UA;
    unique case (gain)
      GAIN_SEL_10X: s = STEP_GAIN10_UA;
      GAIN_SEL_20X: s = STEP_GAIN20_UA;
      GAIN_SEL_30X: s = STEP_GAIN30_UA;
      GAIN_SEL_40X: s = STEP_GAIN40_UA;
    endcase
    return s;
  endfunction

  // signed result, low codes go negative and trip even at zero reverse current
  function automatic logic signed [26:0] thr_of(input logic [7:0] code,
                                                input logic [1:0] gain);
    logic [24:0] prod;
    // widen both operands first so the product is never cut to 17 bits
    prod = 25'(code) * 25'(step_of(gain));
    return $signed({2'b00, prod}) - OFFSET_UA;
  endfunction

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [7:0] limit_two_reg, limit_two_next;
  logic [7:0] limit_three_reg, limit_three_next;
  logic [7:0] rdata_reg, rdata_next;
  logic signed [26:0] thr_two_reg, thr_two_next;
  logic signed [26:0] thr_three_reg, thr_three_next;
  logic [1:0] flags_reg, flags_next;
  logic alert_reg, alert_next;
  logic [1:0] trip;

  // register writes and registered read data
  always_comb begin
    limit_two_next = limit_two_reg;
    limit_three_next = limit_three_reg;
    rdata_next = rdata_reg;
    if (i_reg_wr && i_reg_addr == ADDR_LIMIT_TWO) begin
      limit_two_next = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == ADDR_LIMIT_THREE) begin
      limit_three_next = i_reg_wdata;
    end
    if (i_reg_rd) begin
      // unmapped addresses read as zero
      unique case (i_reg_addr)
        ADDR_LIMIT_TWO: rdata_next = limit_two_reg;
        ADDR_LIMIT_THREE: rdata_next = limit_three_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // thresholds recomputed every cycle so gain changes apply one clock later
  always_comb begin
    thr_two_next = thr_of(limit_two_reg, i_sense_gain_select);
    thr_three_next = thr_of(limit_three_reg, i_sense_gain_select);
  end

  // sticky flags; a trip in the clear cycle wins over the clear
  always_comb begin
    trip[0] = i_reverse_mode && (i_reverse_current_ua > thr_two_reg);
    trip[1] = i_reverse_mode && (i_reverse_current_ua > thr_three_reg);
    flags_next = (flags_reg & ~i_flag_clear) | trip;
    alert_next = |(flags_reg & i_alert_unmask);
  end

  // single register stage for all state, reset asynchronously to the limit codes and zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      limit_two_reg <= RESET_LIMIT_TWO;
      limit_three_reg <= RESET_LIMIT_THREE;
      rdata_reg <= 8'h00;
      thr_two_reg <= 27'sd0;
      thr_three_reg <= 27'sd0;
      flags_reg <= 2'b00;
      alert_reg <= 1'b0;
    end else begin
      limit_two_reg <= limit_two_next;
      limit_three_reg <= limit_three_next;
      rdata_reg <= rdata_next;
      thr_two_reg <= thr_two_next;
      thr_three_reg <= thr_three_next;
      flags_reg <= flags_next;
      alert_reg <= alert_next;
    end
  end

  // outputs straight from flops
  assign o_reg_rdata = rdata_reg;
  assign o_second_threshold_ua = thr_two_reg;
  assign o_third_threshold_ua = thr_three_reg;
  assign o_limit_flags = flags_reg;
  assign o_alert = alert_reg;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  AST_LIMIT_TWO_WRITE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_reg_wr && i_reg_addr == ADDR_LIMIT_TWO) |=>
      (limit_two_reg == $past(i_reg_wdata)))
    else $error("second limit write not stored");

  AST_LIMIT_THREE_WRITE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_reg_wr && i_reg_addr == ADDR_LIMIT_THREE) |=>
      (limit_three_reg == $past(i_reg_wdata)))
    else $error("third limit write not stored");

  AST_LIMIT_THREE_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(i_reg_wr && i_reg_addr == ADDR_LIMIT_THREE) |=>
      $stable(limit_three_reg))
    else $error("third limit changed without a write");

  AST_READ_BACK: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_reg_rd && !i_reg_wr && i_reg_addr == ADDR_LIMIT_TWO) |=>
      (o_reg_rdata == limit_two_reg))
    else $error("second limit read back wrong");

  AST_THRESHOLD_FORMULA: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    // guarded so the edge that leaves reset is not judged
    i_reset_n |=> (o_third_threshold_ua ==
         thr_of($past(limit_three_reg), $past(i_sense_gain_select))))
    else $error("third threshold does not follow code and gain");

  AST_GAIN10_STEP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (limit_two_reg == 8'h06 && i_sense_gain_select == 2'b00) |=>
      (o_second_threshold_ua == 27'sd341520))
    else $error("10x step wrong");

  AST_GAIN40_MIN: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (limit_three_reg == 8'h18 && i_sense_gain_select == 2'b11) |=>
      (o_third_threshold_ua == 27'sd341520))
    else $error("40x select wrong");

  AST_FORWARD_NO_TRIP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!i_reverse_mode && flags_reg == 2'b00) |=> (o_limit_flags == 2'b00))
    else $error("flag set during forward flow");

  AST_ALERT_FOLLOWS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_reverse_mode && i_reverse_current_ua > thr_two_reg &&
     i_alert_unmask[0]) ##1 i_alert_unmask[0] |=> o_alert)
    else $error("unmasked trip gave no alert");

  AST_ALERT_MASKED: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ((o_limit_flags & i_alert_unmask) == 2'b00) |=> !o_alert)
    else $error("alert raised with every set flag masked");

  AST_THIRD_TRIP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_reverse_mode && i_reverse_current_ua > thr_three_reg) |=>
      o_limit_flags[1])
    else $error("third limit trip did not set its flag");

  // a trip arriving with the clear must keep the flag set
  AST_SET_WINS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_flag_clear[0] && i_reverse_mode &&
     i_reverse_current_ua > thr_two_reg) |=> o_limit_flags[0])
    else $error("clear beat a trip in the same cycle");

  AST_FLAG_CLEAR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_flag_clear[0] &&
     !(i_reverse_mode && i_reverse_current_ua > thr_two_reg)) |=>
      !o_limit_flags[0])
    else $error("second limit flag survived its clear");

  AST_RESET_DEFAULTS: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |->
      (limit_two_reg == RESET_LIMIT_TWO &&
       limit_three_reg == RESET_LIMIT_THREE))
    else $error("limit registers missed their reset codes");

  COV_TRIP_TWO: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_limit_flags[0]));
  COV_TRIP_THREE: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_limit_flags[1]));
  COV_ALERT: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_alert));
  COV_SET_CLEAR: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_flag_clear[0] && trip[0]);
  COV_GAIN40_THIRD: cover property (@(posedge i_clk)
    disable iff (!i_reset_n)
    i_sense_gain_select == GAIN_SEL_40X && limit_three_reg == 8'h18);

endmodule
